// ==== core/cpu_core_register_file.sv ====
// CPU core register file: banked data/address registers, bases, PC, stacks, flags
// Summary of operation
// RL1 - Data registers are 16 bits and the first two also split into independent high and low bytes.
// RL2 - The third data register pairs with the first and the fourth with the second as 32-bit registers.
// RL3 - The two 16-bit address registers serve addressing and arithmetic and pair into one 32-bit register.
// RL4 - The frame base is a 16-bit register that bases frame-relative addressing.
// RL5 - The static base is a 16-bit register that bases static-relative addressing.
// RL6 - The vector table base is 20 bits and holds the start of the interrupt vector table.
// RL7 - The program counter is 20 bits and always holds the address of the next instruction.
// RL8 - Separate 16-bit user and interrupt stack pointers exist and the stack-select flag picks one.
// RL9 - The flag register is 11 bits and reflects the processor state.
// RL10 - The carry flag takes the carry, borrow or shifted-out bit of each unit operation.
// RL11 - Software keeps the debug flag at 0, as it is for debugging only.
// RL12 - The zero flag goes to 1 on a zero result and to 0 on any nonzero result.
// RL13 - The sign flag goes to 1 on a negative result and to 0 otherwise.
// RL14 - Bank-select flag 0 makes register bank 0 active and 1 makes bank 1 active.
// RL15 - The overflow flag goes to 1 when an operation overflows and to 0 otherwise.
// RL16 - A cleared stack-select flag makes the interrupt stack active and a set one the user stack.
`timescale 1ns/10ps
module cpu_core_register_file (
   input  wire logic                               i_clk,
   input  wire logic                               i_rst,
   input  wire logic [cpu_regs_pkg::W_IDX-1:0]     i_addr,
   input  wire logic [cpu_regs_pkg::W_BUS-1:0]     i_wdata,
   input  wire logic                               i_wr,
   input  wire logic                               i_rd,
   output logic      [cpu_regs_pkg::W_BUS-1:0]     o_rdata,
   input  wire cpu_regs_pkg::core_wr_t             i_core_wr,
   input  wire cpu_regs_pkg::core_rd_t             i_core_rd,
   output logic      [cpu_regs_pkg::W_BUS-1:0]     o_core_rdata,
   input  wire cpu_regs_pkg::alu_res_t             i_alu,
   input  wire cpu_regs_pkg::pc_ctl_t              i_pc,
   output logic      [cpu_regs_pkg::W_ADDR20-1:0]  o_pc,
   output logic      [cpu_regs_pkg::W_WORD-1:0]    o_sp,
   output logic      [cpu_regs_pkg::W_WORD-1:0]    o_fb,
   output logic      [cpu_regs_pkg::W_WORD-1:0]    o_sb,
   output logic      [cpu_regs_pkg::W_ADDR20-1:0]  o_vtb,
   output logic      [cpu_regs_pkg::W_FLAGS-1:0]   o_flags,
   output logic                                    o_bank
);
   import cpu_regs_pkg::*;

   // ==========================================
   // Helper functions
   function automatic logic res_zero(acc_size_t sz, logic [W_BUS-1:0] r);
      case (sz)
         SZ_32:   res_zero = (r == '0);
         SZ_16:   res_zero = (r[W_WORD-1:0] == '0);
         default: res_zero = (r[BYTE_W-1:0] == '0);
      endcase
   endfunction

   function automatic logic res_sign(acc_size_t sz, logic [W_BUS-1:0] r);
      case (sz)
         SZ_32:   res_sign = r[W_BUS-1];
         SZ_16:   res_sign = r[W_WORD-1];
         default: res_sign = r[BYTE_W-1];
      endcase
   endfunction

   function automatic logic pair_ok(reg_sel_t s);
      pair_ok = (s == SEL_D0) || (s == SEL_D1) || (s == SEL_A0);
   endfunction

   function automatic logic byte_ok(reg_sel_t s);
      byte_ok = (s == SEL_D0) || (s == SEL_D1);
   endfunction

   function automatic logic [SLOT_W-1:0] pair_slot(reg_sel_t s);
      case (s)
         SEL_D0:  pair_slot = SLOT_W'(SEL_D2);
         SEL_D1:  pair_slot = SLOT_W'(SEL_D3);
         default: pair_slot = SLOT_W'(SEL_A1);
      endcase
   endfunction

   // ==========================================
   // State
   logic [W_WORD-1:0]   gpr_reg  [N_BANK][N_BANKED];
   logic [W_WORD-1:0]   gpr_next [N_BANK][N_BANKED];
   logic [W_WORD-1:0]   sb_reg, sb_next;
   logic [W_WORD-1:0]   usp_reg, usp_next;
   logic [W_WORD-1:0]   isp_reg, isp_next;
   logic [W_ADDR20-1:0] vtb_reg, vtb_next;
   logic [W_ADDR20-1:0] pc_reg, pc_next;
   logic [W_FLAGS-1:0]  flg_reg, flg_next;
   logic [W_BUS-1:0]    bus_rdata, core_rdata;

   function automatic logic [W_ADDR20-1:0] word_of(reg_sel_t s, logic b);
      case (s)
         SEL_SB:  word_of = W_ADDR20'(sb_reg);
         SEL_VTB: word_of = vtb_reg;
         SEL_SP:  word_of = W_ADDR20'(flg_reg[F_U] ? usp_reg : isp_reg);
         SEL_USP: word_of = W_ADDR20'(usp_reg);
         SEL_ISP: word_of = W_ADDR20'(isp_reg);
         SEL_FLG: word_of = W_ADDR20'(flg_reg);
         default: word_of = W_ADDR20'(gpr_reg[b][SLOT_W'(s)]);
      endcase
   endfunction

   // ==========================================
   // Decode
   wire            bank      = flg_reg[F_B];                      // see RL14
   wire            sp_user   = flg_reg[F_U];                      // see RL16
   wire            bus_bank  = i_addr[IX_BANK_BIT];
   wire [SLOT_W-1:0] bus_slot = i_addr[SLOT_W-1:0];
   wire            bus_gpr   = !i_addr[IX_HI_BIT] && (bus_slot != SLOT_NONE);
   wire            bus_gpr_w = i_wr && bus_gpr;
   wire            cw        = i_core_wr.en;
   wire reg_sel_t  csel      = i_core_wr.sel;
   wire [SLOT_W-1:0] cslot   = SLOT_W'(csel);
   wire            c_gpr     = cw && (csel <= SEL_FB);
   wire [W_BUS-1:0] cdata    = i_core_wr.data;
   wire            c_usp     = cw && ((csel == SEL_USP) || (csel == SEL_SP && sp_user));   // see RL8
   wire            c_isp     = cw && ((csel == SEL_ISP) || (csel == SEL_SP && !sp_user));  // see RL16
   wire            flg_wr_c  = cw && (csel == SEL_FLG);
   wire            flg_wr_b  = i_wr && (i_addr == IX_FLG);
   wire            alu_zero  = res_zero(i_alu.size, i_alu.result);
   wire            alu_sign  = res_sign(i_alu.size, i_alu.result);
   logic [W_ADDR20-1:0] rd_lo;
   wire [W_WORD-1:0] rd_hi   = gpr_reg[bank][pair_slot(i_core_rd.sel)];

   // Process form, so a register change re-evaluates the selection
   always_comb begin
      rd_lo = word_of(i_core_rd.sel, bank);
   end

   // ==========================================
   // Banked data and address registers
   always_comb begin
      gpr_next = gpr_reg;
      if (c_gpr) begin
         case (i_core_wr.size)
            SZ_LO8: if (byte_ok(csel)) begin
               gpr_next[bank][cslot][BYTE_W-1:0] = cdata[BYTE_W-1:0];        // see RL1
            end
            SZ_HI8: if (byte_ok(csel)) begin
               gpr_next[bank][cslot][W_WORD-1:BYTE_W] = cdata[BYTE_W-1:0];   // see RL1
            end
            SZ_16: gpr_next[bank][cslot] = cdata[W_WORD-1:0];                 // see RL3
            SZ_32: if (pair_ok(csel)) begin
               gpr_next[bank][cslot] = cdata[W_WORD-1:0];                     // see RL2
               gpr_next[bank][pair_slot(csel)] = cdata[W_BUS-1:W_WORD];       // see RL3
            end
         endcase
      end
      if (bus_gpr_w) begin
         gpr_next[bus_bank][bus_slot] = i_wdata[W_WORD-1:0];
      end
   end

   // ==========================================
   // Stack pointers, static base, vector table base
   assign usp_next = (i_wr && i_addr == IX_USP) ? i_wdata[W_WORD-1:0] :
                     c_usp ? cdata[W_WORD-1:0] : usp_reg;
   assign isp_next = (i_wr && i_addr == IX_ISP) ? i_wdata[W_WORD-1:0] :
                     c_isp ? cdata[W_WORD-1:0] : isp_reg;
   assign sb_next  = (i_wr && i_addr == IX_SB) ? i_wdata[W_WORD-1:0] :
                     (cw && csel == SEL_SB) ? cdata[W_WORD-1:0] : sb_reg;          // see RL5
   assign vtb_next = (i_wr && i_addr == IX_VTB) ? i_wdata[W_ADDR20-1:0] :
                     (cw && csel == SEL_VTB) ? cdata[W_ADDR20-1:0] : vtb_reg;      // see RL6

   // ==========================================
   // Program counter
   assign pc_next = (i_wr && i_addr == IX_PC) ? i_wdata[W_ADDR20-1:0] :
                    i_pc.load ? i_pc.target :
                    i_pc.adv ? W_ADDR20'(pc_reg + W_ADDR20'(i_pc.step)) : pc_reg;  // see RL7

   // ==========================================
   // Flags
   always_comb begin
      flg_next = flg_reg;
      if (i_alu.upd_c) begin
         flg_next[F_C] = i_alu.carry;                                          // see RL10
      end
      if (i_alu.upd_zs) begin
         flg_next[F_Z] = alu_zero;                                             // see RL12
         flg_next[F_S] = alu_sign;                                             // see RL13
      end
      if (i_alu.upd_o) begin
         flg_next[F_O] = i_alu.ovf;                                            // see RL15
      end
      if (flg_wr_c) begin
         flg_next = cdata[W_FLAGS-1:0];                                        // see RL9
      end
      if (flg_wr_b) begin
         flg_next = i_wdata[W_FLAGS-1:0];
      end
   end

   // ==========================================
   // Read paths
   always_comb begin
      bus_rdata = '0;
      if (bus_gpr) begin
         bus_rdata = W_BUS'(gpr_reg[bus_bank][bus_slot]);
      end else begin
         case (i_addr)
            IX_SB:   bus_rdata = W_BUS'(sb_reg);
            IX_VTB:  bus_rdata = W_BUS'(vtb_reg);
            IX_PC:   bus_rdata = W_BUS'(pc_reg);
            IX_USP:  bus_rdata = W_BUS'(usp_reg);
            IX_ISP:  bus_rdata = W_BUS'(isp_reg);
            IX_FLG:  bus_rdata = W_BUS'(flg_reg);
            IX_SP:   bus_rdata = W_BUS'(sp_user ? usp_reg : isp_reg);
            default: bus_rdata = '0;
         endcase
      end
   end

   always_comb begin
      case (i_core_rd.size)
         SZ_LO8: core_rdata = W_BUS'(rd_lo[BYTE_W-1:0]);
         SZ_HI8: core_rdata = W_BUS'(rd_lo[W_WORD-1:BYTE_W]);
         SZ_16:  core_rdata = W_BUS'(rd_lo);
         SZ_32:  core_rdata = pair_ok(i_core_rd.sel) ? {rd_hi, rd_lo[W_WORD-1:0]} : W_BUS'(rd_lo);
      endcase
   end

   // ==========================================
   // Registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int b = 0; b < N_BANK; b++) begin
            for (int s = 0; s < N_BANKED; s++) begin
               gpr_reg[b][s] <= WORD_RST;
            end
         end
      end else begin
         gpr_reg <= gpr_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sb_reg  <= WORD_RST;
         usp_reg <= WORD_RST;
         isp_reg <= WORD_RST;
         vtb_reg <= A20_RST;
         pc_reg  <= A20_RST;
         flg_reg <= FLAGS_RST;
      end else begin
         sb_reg  <= sb_next;
         usp_reg <= usp_next;
         isp_reg <= isp_next;
         vtb_reg <= vtb_next;
         pc_reg  <= pc_next;
         flg_reg <= flg_next;
      end
   end

   // Outputs except the two read data ports track the next values so they equal the registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata      <= '0;
         o_core_rdata <= '0;
         o_pc         <= A20_RST;
         o_sp         <= WORD_RST;
         o_fb         <= WORD_RST;
         o_sb         <= WORD_RST;
         o_vtb        <= A20_RST;
         o_flags      <= FLAGS_RST;
         o_bank       <= 1'b0;
      end else begin
         o_rdata      <= i_rd ? bus_rdata : '0;
         o_core_rdata <= core_rdata;
         o_pc         <= pc_next;
         o_sp         <= flg_next[F_U] ? usp_next : isp_next;                        // see RL8
         o_fb         <= gpr_next[flg_next[F_B]][SLOT_W'(SEL_FB)];                  // see RL4
         o_sb         <= sb_next;
         o_vtb        <= vtb_next;
         o_flags      <= flg_next;
         o_bank       <= flg_next[F_B];                                             // see RL14
      end
   end

   // ==========================================
   // Assertions
   default clocking cb_main @(posedge i_clk); endclocking
   default disable iff (i_rst);

   wire alu_only = !flg_wr_c && !flg_wr_b;

   a_zero_flag: assert property (i_alu.upd_zs && alu_only |=>              // see RL12
      flg_reg[F_Z] == res_zero($past(i_alu.size), $past(i_alu.result)))
      else $error("zero flag does not follow result");
   a_sign_flag: assert property (i_alu.upd_zs && alu_only |=>              // see RL13
      o_flags[F_S] == res_sign($past(i_alu.size), $past(i_alu.result)))
      else $error("sign flag does not follow result");
   a_carry_flag: assert property (i_alu.upd_c && alu_only |=>              // see RL10
      o_flags[F_C] == $past(i_alu.carry))
      else $error("carry flag not captured");
   a_ovf_flag: assert property (i_alu.upd_o && alu_only |=>                // see RL15
      o_flags[F_O] == $past(i_alu.ovf))
      else $error("overflow flag not captured");
   a_stack_select: assert property (cw && csel == SEL_SP && !i_wr |=>   // see RL16
      (($past(sp_user) ? usp_reg : isp_reg) == $past(cdata[W_WORD-1:0])))
      else $error("active stack pointer write went to wrong pointer");
   a_pc_advance: assert property (i_pc.adv && !i_pc.load && !(i_wr && i_addr == IX_PC) |=>   // see RL7
      o_pc == W_ADDR20'($past(o_pc) + W_ADDR20'($past(i_pc.step))))
      else $error("program counter did not advance by step");
   a_byte_split: assert property (c_gpr && i_core_wr.size == SZ_HI8 && csel == SEL_D0 && !i_wr
      |=> gpr_reg[$past(bank)][0][BYTE_W-1:0] == $past(gpr_reg[bank][0][BYTE_W-1:0]))   // see RL1
      else $error("high byte write disturbed low byte");
   a_pair_split: assert property (c_gpr && i_core_wr.size == SZ_32 && csel == SEL_D1 && !i_wr
      |=> gpr_reg[$past(bank)][SLOT_W'(SEL_D3)] == $past(cdata[W_BUS-1:W_WORD]))   // see RL2
      else $error("pair upper half not written");
   a_addr_pair: assert property (c_gpr && i_core_wr.size == SZ_32 && csel == SEL_A0 && !i_wr
      |=> gpr_reg[$past(bank)][SLOT_W'(SEL_A1)] == $past(cdata[W_BUS-1:W_WORD]))   // see RL3
      else $error("address pair upper half not written");
   a_bank_select: assert property (o_bank == flg_reg[F_B] && o_fb == gpr_reg[bank][SLOT_W'(SEL_FB)])  // see RL14
      else $error("bank or frame base output wrong");

   c_pair_write: cover property (c_gpr && i_core_wr.size == SZ_32 && csel == SEL_D0);
   c_alu_zero: cover property (i_alu.upd_zs && alu_zero);
   c_bank_swap: cover property ($changed(o_bank));
   c_stack_swap: cover property ($changed(o_flags[F_U]));
endmodule

// ==== core/cpu_regs_pkg.sv ====
// Constants, selectors and carriers of the CPU core register file
package cpu_regs_pkg;
   // ==========================================
   // Widths
   localparam int W_WORD   = 16;
   localparam int W_ADDR20 = 20;
   localparam int W_FLAGS  = 11;
   localparam int W_BUS    = 32;
   localparam int W_IDX    = 5;
   localparam int BYTE_W   = 8;
   localparam int N_BANK   = 2;
   localparam int N_BANKED = 7;
   localparam int SLOT_W   = 3;
   localparam int W_STEP   = 3;

   // ==========================================
   // Flag bit positions
   localparam int F_C = 0;
   localparam int F_D = 1;
   localparam int F_Z = 2;
   localparam int F_S = 3;
   localparam int F_B = 4;
   localparam int F_O = 5;
   localparam int F_I = 6;
   localparam int F_U = 7;

   // ==========================================
   // Reset values
   localparam logic [W_FLAGS-1:0]  FLAGS_RST = 11'h000;
   localparam logic [W_WORD-1:0]   WORD_RST  = 16'h0000;
   localparam logic [W_ADDR20-1:0] A20_RST   = 20'h00000;

   // ==========================================
   // Register port indices
   localparam int IX_BANK_BIT = 3;
   localparam int IX_HI_BIT   = 4;
   localparam logic [SLOT_W-1:0] SLOT_NONE = 3'h7;
   localparam logic [W_IDX-1:0]  IX_SB  = 5'h10;
   localparam logic [W_IDX-1:0]  IX_VTB = 5'h11;
   localparam logic [W_IDX-1:0]  IX_PC  = 5'h12;
   localparam logic [W_IDX-1:0]  IX_USP = 5'h13;
   localparam logic [W_IDX-1:0]  IX_ISP = 5'h14;
   localparam logic [W_IDX-1:0]  IX_FLG = 5'h15;
   localparam logic [W_IDX-1:0]  IX_SP  = 5'h16;

   // ==========================================
   // Selectors and carriers
   typedef enum logic [3:0] {
      SEL_D0, SEL_D1, SEL_D2, SEL_D3, SEL_A0, SEL_A1, SEL_FB,
      SEL_SB, SEL_VTB, SEL_SP, SEL_USP, SEL_ISP, SEL_FLG
   } reg_sel_t;

   typedef enum logic [1:0] {SZ_LO8, SZ_HI8, SZ_16, SZ_32} acc_size_t;

   typedef struct packed {
      logic             en;
      reg_sel_t         sel;
      acc_size_t        size;
      logic [W_BUS-1:0] data;
   } core_wr_t;

   typedef struct packed {
      reg_sel_t  sel;
      acc_size_t size;
   } core_rd_t;

   typedef struct packed {
      logic             upd_c;
      logic             upd_zs;
      logic             upd_o;
      acc_size_t        size;
      logic [W_BUS-1:0] result;
      logic             carry;
      logic             ovf;
   } alu_res_t;

   typedef struct packed {
      logic                load;
      logic                adv;
      logic [W_STEP-1:0]   step;
      logic [W_ADDR20-1:0] target;
   } pc_ctl_t;
endpackage

// ==== test/alu_seq_model.sv ====
// Behavioural arithmetic unit and sequencer feeding the register file
`timescale 1ns/10ps
module alu_seq_model (
   input  wire logic                              i_clk,
   input  wire logic                              i_rst,
   input  wire logic                              i_go,
   input  wire logic                              i_slow,
   input  wire logic [cpu_regs_pkg::W_WORD-1:0]   i_a,
   input  wire logic [cpu_regs_pkg::W_WORD-1:0]   i_b,
   output cpu_regs_pkg::alu_res_t                 o_alu,
   output cpu_regs_pkg::pc_ctl_t                  o_pc
);
   import cpu_regs_pkg::*;
   logic            go_q;
   logic            fire;
   logic [W_WORD:0] sum;
   logic            ovf;
   // ==========================================
   // Result sources, prompt or one cycle late
   assign fire = i_slow ? go_q : i_go;
   assign sum  = {1'b0, i_a} + {1'b0, i_b};
   assign ovf  = (i_a[15] == i_b[15]) && (sum[15] != i_a[15]);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         go_q  <= 1'b0;
         o_alu <= '0;
         o_pc  <= '0;
      end else begin
         go_q  <= i_go;
         o_alu <= '0;
         o_pc  <= '0;
         if (fire) begin
            // Debug flag is never touched, only the update bits
            o_alu <= '{1'b1, 1'b1, 1'b1, SZ_16, {16'h0000, sum[15:0]}, sum[16], ovf};
            o_pc  <= '{1'b0, 1'b1, 3'h2, 20'h00000};
         end
      end
   end
endmodule

// ==== test/cpu_core_register_file_bench.sv ====
// Self-checking bench for the CPU core register file
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; $display("unexpected t=%0t got=%h exp=%h", $time, got, exp); end end
module cpu_core_register_file_bench;
   import cpu_regs_pkg::*;
   // ==========================================
   // Signals
   logic                i_clk, i_rst, i_wr, i_rd, go, slow, rd_d, cr_d, cr_on;
   logic [W_IDX-1:0]    i_addr;
   logic [W_BUS-1:0]    i_wdata, o_rdata, o_core_rdata;
   core_wr_t            i_core_wr;
   core_rd_t            i_core_rd;
   alu_res_t            alu;
   pc_ctl_t             pcc;
   logic [W_ADDR20-1:0] o_pc, o_vtb;
   logic [W_WORD-1:0]   o_sp, o_fb, o_sb, op_a, op_b;
   logic [W_FLAGS-1:0]  o_flags;
   logic                o_bank;
   logic [W_BUS-1:0]    m [0:31];
   logic [W_BUS-1:0]    rq [$];
   logic [W_BUS-1:0]    cq [$];
   logic [W_BUS-1:0]    exp_r, exp_c;
   int                  n_fail, tests_run, seed;
   // ==========================================
   // Design and partner
   cpu_core_register_file u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_core_wr(i_core_wr), .i_core_rd(i_core_rd), .o_core_rdata(o_core_rdata),
      .i_alu(alu), .i_pc(pcc), .o_pc(o_pc), .o_sp(o_sp), .o_fb(o_fb), .o_sb(o_sb), .o_vtb(o_vtb),
      .o_flags(o_flags), .o_bank(o_bank));
   alu_seq_model u_partner (
      .i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_slow(slow), .i_a(op_a), .i_b(op_b),
      .o_alu(alu), .o_pc(pcc));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // ==========================================
   // Helpers
   function automatic logic [W_BUS-1:0] msk(int i);
      if (i <= 6 || (i >= 8 && i <= 14) || i == 16 || i == 19 || i == 20) return 32'h0000ffff;
      if (i == 17 || i == 18) return 32'h000fffff;
      if (i == 21) return 32'h000007ff;
      return 32'h00000000;
   endfunction
   function automatic logic [W_BUS-1:0] ev(int i);
      if (i == 22) return m[21][F_U] ? m[19] : m[20];
      return m[i];
   endfunction
   task automatic wr(int i, logic [W_BUS-1:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= W_IDX'(i);
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      m[i] = d & msk(i);
   endtask
   task automatic rd(int i);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= W_IDX'(i);
      rq.push_back(ev(i));
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask
   task automatic cw(reg_sel_t s, acc_size_t z, logic [W_BUS-1:0] d);
      @(posedge i_clk);
      i_core_wr <= '{1'b1, s, z, d};
      @(posedge i_clk);
      i_core_wr.en <= 1'b0;
   endtask
   task automatic cr(reg_sel_t s, acc_size_t z, logic [W_BUS-1:0] e);
      @(posedge i_clk);
      i_core_rd <= '{s, z};
      cr_on <= 1'b1;
      cq.push_back(e);
      @(posedge i_clk);
      cr_on <= 1'b0;
   endtask
   task automatic op(logic [15:0] a, logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      @(posedge i_clk);
      go <= 1'b1;
      op_a <= a;
      op_b <= b;
      slow <= 1'($random(seed));
      @(posedge i_clk);
      go <= 1'b0;
      @(posedge i_clk);
      m[21][F_C] = s[16];
      m[21][F_Z] = (s[15:0] == 16'h0000);
      m[21][F_S] = s[15];
      m[21][F_O] = (a[15] == b[15]) && (s[15] != a[15]);
      m[18] = (m[18] + 32'h2) & 32'h000fffff;
   endtask
   task automatic tally_and_finish();
      if (rq.size() + cq.size() != 0) n_fail++;
      if (n_fail == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================
   // Result watcher
   always @(posedge i_clk) begin
      if (rd_d) begin
         exp_r = rq.pop_front();
         `CHK(o_rdata, exp_r)
      end
      if (cr_d) begin
         exp_c = cq.pop_front();
         `CHK(o_core_rdata, exp_c)
      end
      rd_d <= i_rd;
      cr_d <= cr_on;
   end
   initial begin
      #1000000;
      n_fail++;
      tally_and_finish();
   end
   // ==========================================
   // Main sequence
   initial begin
      seed = 98;
      n_fail = 0;
      tests_run = 0;
      i_rst = 1'b1;
      {i_wr, i_rd, go, slow, rd_d, cr_d, cr_on} = '0;
      i_addr = '0;
      i_wdata = '0;
      i_core_wr = '0;
      i_core_rd = '0;
      op_a = '0;
      op_b = '0;
      foreach (m[i]) m[i] = '0;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 24; i++) rd(i);
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 24; i++) if (i != 21) wr(i, $random(seed));
         wr(21, ($random(seed) & 32'h0000076d) | (k << F_U) | (k << F_B));
         for (int i = 0; i < 24; i++) rd(i);
         `CHK(o_sp, m[k ? 19 : 20][15:0])
         `CHK(o_fb, m[k ? 14 : 6][15:0])
         `CHK(o_bank, 1'(k))
         `CHK(o_sb, m[16][15:0])
         `CHK(o_vtb, m[17][19:0])
         `CHK(o_pc, m[18][19:0])
         `CHK(o_flags, m[21][10:0])
      end
      cw(SEL_D0, SZ_32, 32'h12345678);
      m[8] = 32'h00005678;
      m[10] = 32'h00001234;
      cw(SEL_D1, SZ_32, 32'h0badf00d);
      m[9] = 32'h0000f00d;
      m[11] = 32'h00000bad;
      cw(SEL_D1, SZ_HI8, 32'h000000ab);
      m[9][15:8] = 8'hab;
      cw(SEL_D0, SZ_LO8, 32'h000000cd);
      m[8][7:0] = 8'hcd;
      cw(SEL_D0, SZ_HI8, 32'h00000077);
      m[8][15:8] = 8'h77;
      cw(SEL_SP, SZ_16, 32'h00005a5a);
      m[19] = 32'h00005a5a;
      cw(SEL_D2, SZ_HI8, 32'h000000ee);
      cw(SEL_A0, SZ_32, 32'h9abcdef0);
      m[12] = 32'h0000def0;
      m[13] = 32'h00009abc;
      for (int i = 0; i < 14; i++) rd(i);
      cr(SEL_D0, SZ_32, {m[10][15:0], m[8][15:0]});
      cr(SEL_D1, SZ_HI8, 32'h000000ab);
      cr(SEL_A0, SZ_32, {m[13][15:0], m[12][15:0]});
      cr(SEL_D1, SZ_32, {m[11][15:0], m[9][15:0]});
      cr(SEL_SP, SZ_16, m[19]);
      wr(18, 32'h000ffffe);
      op(16'h0000, 16'h0000);
      rd(21);
      op(16'hffff, 16'h0001);
      rd(21);
      op(16'h7fff, 16'h0001);
      rd(21);
      repeat (4) begin
         op(16'($random(seed)), 16'($random(seed)));
         rd(21);
      end
      rd(18);
      `CHK(o_pc, m[18][19:0])
      @(posedge i_clk);
      i_rst <= 1'b1;
      @(posedge i_clk);
      i_rst <= 1'b0;
      foreach (m[i]) m[i] = '0;
      for (int i = 0; i < 24; i++) rd(i);
      repeat (3) @(posedge i_clk);
      tally_and_finish();
   end
endmodule
